/* File: hw/spi_port_end.sv */
`timescale 1ns/1ps
`include "spi_consts.svh"
module spi_port_end (
  input  logic           clk_sys,
  input  logic           rst_n,
  spi_link_if.dev        link,
  input  logic           ctrlWrite,
  input  spi_pkg::ctrl_t ctrlWrData,
  output spi_pkg::ctrl_t ctrlRdData,
  input  logic           bufWrite,
  input  spi_pkg::word_t bufWrData,
  input  logic           bufRead,
  output spi_pkg::word_t bufRdData,
  output logic           txBufEmpty,
  output logic           rxFull,
  output logic           busy,
  output logic           cfgInvalid
);
  import spi_pkg::*;

  logic [2:0]            syncAQ;
  logic [2:0]            syncBQ;
  logic                  sckPrevQ;
  ctrl_t                 ctrlQ, ctrlD;
  word_t                 txBufQ, txBufD;
  logic                  txFullQ, txFullD;
  word_t                 rxBufQ, rxBufD;
  logic                  rxFullQ, rxFullD;
  word_t                 shiftQ, shiftD;
  logic [`SPI_CNT_W-1:0] cntQ, cntD;
  logic                  sampQ, sampD;
  logic [`SPI_DIV_W-1:0] divQ, divD;
  logic                  sckOQ, sckOD;
  logic                  ssOQ, ssOD;
  logic                  sdoQ, sdoD;
  logic                  busyQ, busyD;
  logic                  invalidQ, invalidD;

  logic sckS, ssS, sdiS;
  logic framed, cpol, fsp, effSsen, tick, lead, trail, start, bitIn, sel;

  assign sckS = syncBQ[2];
  assign ssS  = syncBQ[1];
  assign sdiS = syncBQ[0];

  always_comb begin
    ctrlD    = ctrlQ;
    txBufD   = txBufQ;
    txFullD  = txFullQ;
    rxBufD   = rxBufQ;
    rxFullD  = rxFullQ;
    shiftD   = shiftQ;
    cntD     = cntQ;
    sampD    = sampQ;
    divD     = divQ;
    sckOD    = sckOQ;
    ssOD     = ssOQ;
    sdoD     = sdoQ;
    busyD    = busyQ;
    framed   = ctrlQ.frameModeEnable;
    cpol     = ctrlQ.clockIdlePolarity;
    fsp      = ctrlQ.frameSyncPolarity;
    effSsen  = ctrlQ.slaveSelectEnable & ~framed;
    invalidD = ctrlQ.slaveSelectEnable & framed;
    tick     = (divQ == `SPI_DIV_W'(`SPI_HALF_CYC - 1));
    lead     = 1'b0;
    trail    = 1'b0;
    start    = 1'b0;
    sel      = 1'b1;
    bitIn    = (ctrlQ.masterEnable & ctrlQ.inputSamplePhase) ? sdiS : sampQ;

    if (ctrlQ.masterEnable) begin
      divD = tick ? '0 : divQ + `SPI_DIV_W'(1);
      // Framed clock free-runs, otherwise only during a word
      if (tick && (framed || busyQ)) begin
        lead  = (sckOQ == cpol);
        trail = (sckOQ != cpol);
      end
      if (!framed && !busyQ) begin
        sckOD = cpol;
      end
      if (framed) begin
        start = txFullQ && trail && (!busyQ || cntQ == `SPI_CNT_W'(1));
      end else begin
        start = txFullQ && !busyQ;
      end
    end else begin
      sckOD = cpol;
      lead  = (sckS != sckPrevQ) && (sckS != cpol);
      trail = (sckS != sckPrevQ) && (sckS == cpol);
      // Without slave select every edge counts, so a stray edge slips words
      sel   = !effSsen || !ssS;
    end

    if (lead) begin
      sckOD = ~cpol;
      if (!ctrlQ.inputSamplePhase || !ctrlQ.masterEnable) begin
        sampD = sdiS;
      end
    end

    if (trail) begin
      sckOD = cpol;
      if (busyQ) begin
        shiftD = {shiftQ[`SPI_WORD_BITS-2:0], bitIn};
        sdoD   = shiftQ[`SPI_WORD_BITS-2];
        cntD   = cntQ - `SPI_CNT_W'(1);
        if (cntQ == `SPI_CNT_W'(1)) begin
          rxBufD  = {shiftQ[`SPI_WORD_BITS-2:0], bitIn};
          rxFullD = 1'b1;
          busyD   = 1'b0;
        end
      end
    end

    if (!ctrlQ.masterEnable) begin
      if (!sel) begin
        busyD = 1'b0;
        cntD  = '0;
      end else if (lead && !busyQ && (!framed || ssS == fsp)) begin
        start = 1'b1;
      end
    end

    if (start) begin
      shiftD  = txFullQ ? txBufQ : '0;
      txFullD = 1'b0;
      busyD   = 1'b1;
      cntD    = `SPI_CNT_W'(`SPI_WORD_BITS);
      if (ctrlQ.masterEnable) begin
        sdoD = txBufQ[`SPI_WORD_BITS-1];
        if (!framed) begin
          divD = '0;
        end
      end
    end else if (!busyD && !ctrlQ.masterEnable) begin
      sdoD = txBufQ[`SPI_WORD_BITS-1];
    end

    if (ctrlQ.masterEnable) begin
      if (framed) begin
        if (start) begin
          ssOD = fsp;
        end else if (trail || !busyQ) begin
          ssOD = ~fsp;
        end
      end else begin
        ssOD = ~busyD;
      end
    end else begin
      ssOD = framed ? ~fsp : 1'b1;
    end

    if (ctrlWrite) begin
      ctrlD = ctrlWrData;
      ctrlD.inputSamplePhase = ctrlWrData.inputSamplePhase & ctrlWrData.masterEnable;
    end
    if (bufRead) begin
      rxFullD = rxFullD & ~rxFullQ | (trail && busyQ && cntQ == `SPI_CNT_W'(1));
    end
    if (bufWrite) begin
      txBufD  = bufWrData;
      txFullD = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    syncAQ   <= {link.sck, link.ss, link.parSdo};
    syncBQ   <= syncAQ;
    sckPrevQ <= syncBQ[2];
    if (!rst_n) begin
      ctrlQ    <= '0;
      txBufQ   <= '0;
      txFullQ  <= 1'b0;
      rxBufQ   <= '0;
      rxFullQ  <= 1'b0;
      shiftQ   <= '0;
      cntQ     <= '0;
      sampQ    <= 1'b0;
      divQ     <= '0;
      sckOQ    <= 1'b0;
      ssOQ     <= 1'b1;
      sdoQ     <= 1'b0;
      busyQ    <= 1'b0;
      invalidQ <= 1'b0;
    end else begin
      ctrlQ    <= ctrlD;
      txBufQ   <= txBufD;
      txFullQ  <= txFullD;
      rxBufQ   <= rxBufD;
      rxFullQ  <= rxFullD;
      shiftQ   <= shiftD;
      cntQ     <= cntD;
      sampQ    <= sampD;
      divQ     <= divD;
      sckOQ    <= sckOD;
      ssOQ     <= ssOD;
      sdoQ     <= sdoD;
      busyQ    <= busyD;
      invalidQ <= invalidD;
    end
  end

  assign link.devSckO  = sckOQ;
  assign link.devSckOe = ctrlQ.masterEnable;
  assign link.devSsO   = ssOQ;
  assign link.devSsOe  = ctrlQ.masterEnable;
  assign link.devSdo   = sdoQ;
  assign ctrlRdData    = ctrlQ;
  assign bufRdData     = rxBufQ;
  assign txBufEmpty    = ~txFullQ;
  assign rxFull        = rxFullQ;
  assign busy          = busyQ;
  assign cfgInvalid    = invalidQ;
endmodule

/* File: hw/spi_consts.svh */
// Behaviour
// - Framed mode keeps the serial clock running.
// - Frame sync pulse on slave select marks frames.
// - Frame mode with slave select enable is invalid.
// - Sample phase set only with master enable.
// - Masters should use late sampling for speed.
// - Transfer start copies buffer into shift register.
// - Buffer reads empty once transmission begins.
// - Master waits for slave to load buffer; the port master starts as soon as its own buffer is full.
// - Load transmit buffer before the next transaction.
// - Unselected slave ignores clock edges and drops a partial word.
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH
`define SPI_WORD_BITS 16
`define SPI_CNT_W 5
`define SPI_DIV_W 3
`define SPI_CLK_NS 100
`define SPI_HALF_NS 400
`define SPI_HALF_CYC ((`SPI_HALF_NS + `SPI_CLK_NS - 1) / `SPI_CLK_NS)
`define SPI_GUARD_W 4
`define SPI_GUARD_CYC 8
`endif

/* File: hw/spi_pkg.sv */
package spi_pkg;
  `include "spi_consts.svh"
  typedef logic [`SPI_WORD_BITS-1:0] word_t;
  typedef struct packed {
    logic frameModeEnable;
    logic frameSyncPolarity;
    logic slaveSelectEnable;
    logic clockIdlePolarity;
    logic inputSamplePhase;
    logic masterEnable;
  } ctrl_t;
endpackage

/* File: hw/spi_link_if.sv */
`timescale 1ns/1ps
interface spi_link_if #(
  parameter logic SckPull = 1'b0,
  parameter logic SsPull  = 1'b1
);
  logic devSckO;
  logic devSckOe;
  logic devSsO;
  logic devSsOe;
  logic devSdo;
  logic parSckO;
  logic parSckOe;
  logic parSsO;
  logic parSsOe;
  logic parSdo;
  logic sck;
  logic ss;

  // Wire level from the enables, pull level when nobody drives
  assign sck = devSckOe ? devSckO : (parSckOe ? parSckO : SckPull);
  assign ss  = devSsOe ? devSsO : (parSsOe ? parSsO : SsPull);

  modport dev (output devSckO, devSckOe, devSsO, devSsOe, devSdo,
               input sck, ss, parSdo);
  modport par (output parSckO, parSckOe, parSsO, parSsOe, parSdo,
               input sck, ss, devSdo);
endinterface

/* File: hw/spi_partner_end.sv */
`timescale 1ns/1ps
`include "spi_consts.svh"
module spi_partner_end (
  input  logic           clk_sys,
  input  logic           rst_n,
  spi_link_if.par        link,
  input  logic           masterMode,
  input  logic           frameMode,
  input  logic           frameSyncPolarity,
  input  logic           clockIdlePolarity,
  input  logic           useSlaveSelect,
  input  logic           sampleLate,
  input  logic           txValid,
  input  spi_pkg::word_t txData,
  output logic           txReady,
  output spi_pkg::word_t rxData,
  output logic           rxValid
);
  import spi_pkg::*;

  logic [2:0]              syncAQ;
  logic [2:0]              syncBQ;
  logic                    sckPrevQ;
  word_t                   shiftQ, shiftD;
  word_t                   rxQ, rxD;
  logic                    rxValidQ, rxValidD;
  logic [`SPI_CNT_W-1:0]   cntQ, cntD;
  logic [`SPI_DIV_W-1:0]   divQ, divD;
  logic [`SPI_GUARD_W-1:0] gapQ, gapD;
  logic                    sampQ, sampD;
  logic                    sckOQ, sckOD;
  logic                    ssOQ, ssOD;
  logic                    sdoQ, sdoD;
  logic                    busyQ, busyD;
  logic                    readyQ, readyD;
  logic                    lead, trail, start, bitIn, tick, sel;

  always_comb begin
    shiftD   = shiftQ;
    rxD      = rxQ;
    rxValidD = 1'b0;
    cntD     = cntQ;
    tick     = (divQ == `SPI_DIV_W'(`SPI_HALF_CYC - 1));
    divD     = tick ? '0 : divQ + `SPI_DIV_W'(1);
    gapD     = (gapQ != '0) ? gapQ - `SPI_GUARD_W'(1) : gapQ;
    sampD    = sampQ;
    sckOD    = sckOQ;
    ssOD     = ssOQ;
    sdoD     = sdoQ;
    busyD    = busyQ;
    lead     = 1'b0;
    trail    = 1'b0;
    start    = 1'b0;
    sel      = 1'b1;
    bitIn    = (masterMode & sampleLate) ? syncBQ[0] : sampQ;
    if (masterMode) begin
      if (tick && (frameMode || busyQ)) begin
        lead  = (sckOQ == clockIdlePolarity);
        trail = (sckOQ != clockIdlePolarity);
      end
      if (!frameMode && !busyQ) begin
        sckOD = clockIdlePolarity;
      end
      // Guard gap gives the slave time to reload its buffer
      if (frameMode) begin
        start = txValid && readyQ && trail && (!busyQ || cntQ == `SPI_CNT_W'(1));
      end else begin
        start = txValid && readyQ && !busyQ && gapQ == '0;
      end
    end else begin
      sckOD = clockIdlePolarity;
      lead  = (syncBQ[2] != sckPrevQ) && (syncBQ[2] != clockIdlePolarity);
      trail = (syncBQ[2] != sckPrevQ) && (syncBQ[2] == clockIdlePolarity);
      sel   = frameMode || !useSlaveSelect || !syncBQ[1];
      if (lead && !busyQ && (!frameMode || syncBQ[1] == frameSyncPolarity)) begin
        start = 1'b1;
      end
    end
    if (lead && !(masterMode && sampleLate)) begin
      sampD = syncBQ[0];
    end
    if (lead) begin
      sckOD = ~clockIdlePolarity;
    end
    if (trail) begin
      sckOD = clockIdlePolarity;
      if (busyQ) begin
        shiftD = {shiftQ[`SPI_WORD_BITS-2:0], bitIn};
        sdoD   = shiftQ[`SPI_WORD_BITS-2];
        cntD   = cntQ - `SPI_CNT_W'(1);
        if (cntQ == `SPI_CNT_W'(1)) begin
          rxD      = {shiftQ[`SPI_WORD_BITS-2:0], bitIn};
          rxValidD = 1'b1;
          busyD    = 1'b0;
          gapD     = `SPI_GUARD_W'(`SPI_GUARD_CYC);
        end
      end
    end
    if (!sel) begin
      busyD = 1'b0;
      cntD  = '0;
      start = 1'b0;
    end
    if (start) begin
      shiftD = (txValid && readyQ) ? txData : '0;
      sdoD   = shiftD[`SPI_WORD_BITS-1];
      busyD  = 1'b1;
      cntD   = `SPI_CNT_W'(`SPI_WORD_BITS);
      if (masterMode && !frameMode) begin
        divD = '0;
      end
    end else if (!busyD && !masterMode) begin
      sdoD = txData[`SPI_WORD_BITS-1];
    end
    readyD = ~start;
    if (masterMode && frameMode) begin
      if (start) begin
        ssOD = frameSyncPolarity;
      end else if (trail || !busyQ) begin
        // Idle level outside the pulse, also right after reset
        ssOD = ~frameSyncPolarity;
      end
    end else if (masterMode) begin
      ssOD = ~busyD;
    end
  end

  always_ff @(posedge clk_sys) begin
    syncAQ   <= {link.sck, link.ss, link.devSdo};
    syncBQ   <= syncAQ;
    sckPrevQ <= syncBQ[2];
    if (!rst_n) begin
      shiftQ   <= '0;
      rxQ      <= '0;
      rxValidQ <= 1'b0;
      cntQ     <= '0;
      divQ     <= '0;
      gapQ     <= '0;
      sampQ    <= 1'b0;
      sckOQ    <= 1'b0;
      ssOQ     <= 1'b1;
      sdoQ     <= 1'b0;
      busyQ    <= 1'b0;
      readyQ   <= 1'b0;
    end else begin
      shiftQ   <= shiftD;
      rxQ      <= rxD;
      rxValidQ <= rxValidD;
      cntQ     <= cntD;
      divQ     <= divD;
      gapQ     <= gapD;
      sampQ    <= sampD;
      sckOQ    <= sckOD;
      ssOQ     <= ssOD;
      sdoQ     <= sdoD;
      busyQ    <= busyD;
      readyQ   <= readyD;
    end
  end

  assign link.parSckO  = sckOQ;
  assign link.parSckOe = masterMode;
  assign link.parSsO   = ssOQ;
  assign link.parSsOe  = masterMode;
  assign link.parSdo   = sdoQ;
  assign txReady       = readyQ;
  assign rxData        = rxQ;
  assign rxValid       = rxValidQ;
endmodule

/* File: testbench/spi_framed_serial_port_asserts.sv */
`timescale 1ns/1ps
module spi_framed_serial_port_asserts (
  input logic clk_sys,
  input logic rst_n,
  input logic devSckO,
  input logic devSckOe,
  input logic devSsO,
  input logic devSsOe,
  input logic parSckO,
  input logic parSckOe,
  input logic parSsOe,
  input logic sck,
  input logic ss
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence devQuiet; $stable(devSckO)[*3]; endsequence
  sequence parQuiet; $stable(parSckO)[*3]; endsequence
  AST_DEV_HALF: assert property (devSckOe && $changed(devSckO) |=> devQuiet)
    else $error("device clock half period too short");
  AST_PAR_HALF: assert property (parSckOe && $changed(parSckO) |=> parQuiet)
    else $error("partner clock half period too short");
  AST_DEV_START: assert property (devSckOe && $fell(devSsO) |=> devQuiet)
    else $error("clock edge too soon after word start");
  AST_OE_PAIR: assert property (devSsOe == devSckOe)
    else $error("select and clock enables differ");
  AST_SCK_WIRE: assert property (devSckOe |-> sck == devSckO)
    else $error("clock wire differs from device drive");
  AST_SS_WIRE: assert property (devSsOe |-> ss == devSsO)
    else $error("select wire differs from device drive");
  AST_PAR_WIRE: assert property (!devSckOe && parSckOe |-> sck == parSckO)
    else $error("clock wire differs from partner drive");
  AST_ONE_MASTER: assert property (!(devSckOe && parSckOe))
    else $error("both ends drive the clock");
  AST_SS_PULL: assert property (!devSsOe && !parSsOe |-> ss)
    else $error("undriven select wire not high");
endmodule

/* File: testbench/spi_framed_serial_port_bench.sv */
`timescale 1ns/1ps
module spi_framed_serial_port_bench;
  import spi_pkg::*;
  logic  clk_sys = 1'b0;
  logic  rst_n = 1'b0;
  logic  ctrlWrite = 1'b0;
  ctrl_t ctrlWrData = '0;
  ctrl_t ctrlRdData;
  logic  bufWrite = 1'b0;
  word_t bufWrData = '0;
  logic  bufRead = 1'b0;
  word_t bufRdData;
  logic  txBufEmpty, rxFull, busy, cfgInvalid;
  logic  pMaster = 1'b0, pFrame = 1'b0, pFsp = 1'b0, pCkp = 1'b0;
  logic  pUseSs = 1'b0, pLate = 1'b0, pTxValid = 1'b0;
  word_t pTxData = '0;
  logic  pTxReady, pRxValid;
  word_t pRxData, parRx;
  int    parCnt = 0, cycles = 0, n_errors = 0, num_checks = 0;

  spi_link_if i_spi_link_if ();
  spi_port_end i_spi_port_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_spi_link_if),
    .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData),
    .bufWrite(bufWrite), .bufWrData(bufWrData), .bufRead(bufRead), .bufRdData(bufRdData),
    .txBufEmpty(txBufEmpty), .rxFull(rxFull), .busy(busy), .cfgInvalid(cfgInvalid));
  spi_partner_end i_spi_partner_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_spi_link_if),
    .masterMode(pMaster), .frameMode(pFrame), .frameSyncPolarity(pFsp),
    .clockIdlePolarity(pCkp), .useSlaveSelect(pUseSs), .sampleLate(pLate),
    .txValid(pTxValid), .txData(pTxData), .txReady(pTxReady), .rxData(pRxData),
    .rxValid(pRxValid));
  spi_framed_serial_port_asserts i_spi_framed_serial_port_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .devSckO(i_spi_link_if.devSckO), .devSckOe(i_spi_link_if.devSckOe),
    .devSsO(i_spi_link_if.devSsO), .devSsOe(i_spi_link_if.devSsOe),
    .parSckO(i_spi_link_if.parSckO), .parSckOe(i_spi_link_if.parSckOe),
    .parSsOe(i_spi_link_if.parSsOe), .sck(i_spi_link_if.sck), .ss(i_spi_link_if.ss));

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (pRxValid === 1'b1) begin
      parRx <= pRxData;
      parCnt <= parCnt + 1;
    end
  end

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk_sys);
      #10;
    end
  endtask

  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    num_checks++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic setCtrl(input ctrl_t c);
    ctrlWrData = c;
    ctrlWrite = 1'b1;
    tick();
    ctrlWrite = 1'b0;
    tick(4);
  endtask

  task automatic putBuf(input word_t w);
    bufWrData = w;
    bufWrite = 1'b1;
    tick();
    bufWrite = 1'b0;
  endtask

  task automatic rdBuf(input word_t exp);
    for (int i = 0; i < 400 && rxFull !== 1'b1; i++) tick();
    chk(16'(rxFull), 16'h0001);
    chk(bufRdData, exp);
    bufRead = 1'b1;
    tick();
    bufRead = 1'b0;
  endtask

  task automatic parWait(input int target, input word_t exp);
    for (int i = 0; i < 400 && parCnt < target; i++) tick();
    chk(16'(parCnt >= target), 16'h0001);
    chk(parRx, exp);
  endtask

  task automatic doReset(input logic m, input logic f, input logic fsp);
    pMaster = m;
    pFrame = f;
    pFsp = fsp;
    pCkp = 1'b0;
    pUseSs = 1'b0;
    pLate = m;
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick();
  endtask

  task automatic ctrlRules();
    setCtrl(6'b000010);
    chk(16'(ctrlRdData), 16'h0000);
    setCtrl(6'b000011);
    chk(16'(ctrlRdData), 16'h0003);
    setCtrl(6'b101000);
    chk(16'(cfgInvalid), 16'h0001);
    setCtrl(6'b100000);
    chk(16'(cfgInvalid), 16'h0000);
    setCtrl(6'b000000);
  endtask

  task automatic masterXfer(input logic clock_idle_polarity);
    int c0;
    c0 = parCnt;
    pCkp = clock_idle_polarity;
    pUseSs = 1'b1;
    pTxData = 16'h3c5a;
    pTxValid = 1'b1;
    setCtrl({3'b000, clock_idle_polarity, 1'b1, 1'b1});
    chk(16'(i_spi_link_if.sck), 16'(clock_idle_polarity));
    putBuf(16'ha5c3);
    for (int i = 0; i < 10 && busy !== 1'b1; i++) tick();
    chk(16'(txBufEmpty), 16'h0001);
    putBuf(16'h0ff1);
    rdBuf(16'h3c5a);
    parWait(c0 + 1, 16'ha5c3);
    rdBuf(16'h3c5a);
    parWait(c0 + 2, 16'h0ff1);
    tick(10);
    chk(16'(i_spi_link_if.sck), 16'(clock_idle_polarity));
    pTxValid = 1'b0;
    setCtrl(6'b000000);
  endtask

  task automatic framedXfer(input logic fsp);
    int c0;
    int n;
    logic s;
    logic moved;
    doReset(1'b1, 1'b1, fsp);
    c0 = parCnt;
    setCtrl({1'b1, fsp, 4'b0000});
    putBuf(16'h9e17);
    pTxData = 16'h6b2d;
    pTxValid = 1'b1;
    for (int i = 0; i < 300 && i_spi_link_if.ss !== !fsp; i++) tick();
    for (int i = 0; i < 300 && i_spi_link_if.ss !== fsp; i++) tick();
    n = 0;
    for (int i = 0; i < 20 && i_spi_link_if.ss === fsp; i++) begin
      n++;
      tick();
    end
    chk(16'(n), 16'h0008);
    chk(16'(i_spi_link_if.ss), 16'(!fsp));
    rdBuf(16'h6b2d);
    parWait(c0 + 1, 16'h9e17);
    pTxValid = 1'b0;
    s = i_spi_link_if.sck;
    moved = 1'b0;
    repeat (10) begin
      tick();
      if (i_spi_link_if.sck !== s) moved = 1'b1;
    end
    chk(16'(moved), 16'h0001);
  endtask

  task automatic threeWire();
    int c0;
    doReset(1'b1, 1'b0, 1'b0);
    c0 = parCnt;
    setCtrl(6'b000000);
    putBuf(16'h1234);
    pTxData = 16'hc3e1;
    pTxValid = 1'b1;
    rdBuf(16'hc3e1);
    parWait(c0 + 1, 16'h1234);
    pTxValid = 1'b0;
  endtask

  initial begin
    tick(5);
    rst_n = 1'b1;
    tick();
    chk(16'(ctrlRdData), 16'h0000);
    chk(16'({rxFull, busy}), 16'h0000);
    ctrlRules();
    masterXfer(1'b0);
    masterXfer(1'b1);
    framedXfer(1'b0);
    framedXfer(1'b1);
    threeWire();
    test_done();
  end
endmodule
